// >>> hdl/sdfd_decoder.sv
// module: section descriptor field decoder with input buffering
`timescale 1ns/1ps
`default_nettype none
// Contract
// - mask has one bit per subcarrier; msb is the lowest-frequency subcarrier
// - absent mask defaults to all ones, covering all twelve subcarriers
// - priority coupling: only the highest-priority description configures a subcarrier; code clips a low one only by earlier high-priority bits of its group
// - uncovered subcarriers of a partly covered prb are output as zero
// - prb count is the number of contiguous prbs covered
// - prb count zero means all prbs; starting prb is forced to zero
// - channel-info group size scales prb count only in type 6
// - symbol count 1..14 valid; 0 only with ext 6 or 12; 15 reserved
// - with ext 6, 12 or 19 the symbol set comes from the bitmap
// - extension flag: zero none, one at least one extension
// - beam selector zero means no beamforming, equal drive to all elements
// - beam selectors form one global space of 32767 nonzero beams
// - type 6 ue label is only a stream label with no meaning
// - enabled marker: label all ones, ext 10, kind 10b, type 5 unschedules
// - first prb index is the lowest-frequency prb covered
// - running symbol per message advances by previous count on flag
module sdfd_decoder #(
  parameter int DEPTH = sdfd_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // configuration
  input wire logic priority_coupling,
  input wire logic unscheduled_marker_enable,
  input wire logic [sdfd_pkg::GRP_W-1:0] channel_info_group_size,
  // incoming descriptions
  input wire logic in_valid,
  output logic in_ready,
  input wire sdfd_pkg::sdfd_desc_t in_desc,
  // decoded descriptions
  output logic out_valid,
  input wire logic out_ready,
  output sdfd_pkg::sdfd_out_t out_desc
);
  import sdfd_pkg::*;

  // ----------------------------------------------------------------
  // input buffer
  // ----------------------------------------------------------------
  logic buf_valid;
  logic buf_ready;
  sdfd_desc_t d;
  logic in_ready_unused;
  logic [$bits(sdfd_desc_t)-1:0] buf_data;

  sdfd_fifo #(.WIDTH($bits(sdfd_desc_t)), .DEPTH(DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .wr_valid(in_valid),
    .wr_ready(in_ready_unused),
    .wr_data(in_desc),
    .rd_valid(buf_valid),
    .rd_ready(buf_ready),
    .rd_data(buf_data)
  );
  assign d = sdfd_desc_t'(buf_data);
  assign in_ready = in_ready_unused;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic out_valid_ff;
  sdfd_out_t out_ff;
  logic [SYM_W-1:0] sym_ff;
  logic [SYM_W-1:0] prev_cnt_ff;
  logic [PRB_W-1:0] grp_prb_ff;
  logic [SYM_W-1:0] grp_sym_ff;
  logic [MASK_W-1:0] union_ff;
  logic [MASK_W-1:0] hi_mask_ff;

  assign buf_ready = !out_valid_ff || out_ready;
  wire take = buf_valid && buf_ready;

  // ----------------------------------------------------------------
  // field decode
  // ----------------------------------------------------------------
  wire bitmap_ext = d.has_ext6 || d.has_ext12 || d.has_ext19;
  wire zero_ok = d.has_ext6 || d.has_ext12;
  wire sym_bad = (d.symbol_count == SYM_RSV_HI) ||
                 ((d.symbol_count == SYM_RSV_LO) && !zero_ok);
  wire malformed = sym_bad;

  // running symbol for this description
  wire [SYM_W-1:0] base_sym = d.first_of_msg ? d.start_symbol : sym_ff;
  wire [SYM_W-1:0] base_cnt = d.first_of_msg ? SYM_ONE : prev_cnt_ff;
  wire [SYM_W:0] adv_sum = {1'b0, base_sym} + {1'b0, base_cnt};
  wire [SYM_W-1:0] nxt_sym = d.symbol_advance_flag ? adv_sum[SYM_W-1:0] : base_sym;

  // symbol set from count or from bitmap
  logic [SYMS-1:0] count_set;
  always_comb begin
    count_set = '0;
    for (int i = 0; i < SYMS; i++) begin
      count_set[i] = ({1'b0, SYM_W'(i)} >= {1'b0, nxt_sym}) &&
                     ({1'b0, SYM_W'(i)} < ({1'b0, nxt_sym} + {1'b0, d.symbol_count}));
    end
  end
  wire [SYMS-1:0] sym_set = bitmap_ext ? d.symbol_set_bitmap : count_set;

  // prb span
  wire all_prbs = (d.prb_count == PRB_ALL);
  wire [PRB_W-1:0] first_prb = all_prbs ? PRB_ZERO : d.first_prb_index;
  wire grp_scale = (d.section_type == ST_CHINFO) &&
                   (channel_info_group_size != '0);
  wire [TOT_W-1:0] prb_plain = {{(TOT_W-CNT_W){1'b0}}, d.prb_count};
  wire [TOT_W-1:0] prb_grouped = TOT_W'(d.prb_count) * TOT_W'(channel_info_group_size);
  wire [TOT_W-1:0] prb_total = grp_scale ? prb_grouped : prb_plain;

  // subcarrier mask, bit 11 is the lowest-frequency subcarrier
  wire [MASK_W-1:0] eff_mask = d.mask_given ? d.subcarrier_mask : MASK_ALL;
  wire same_grp = !d.first_of_msg && (first_prb == grp_prb_ff) && (nxt_sym == grp_sym_ff);
  wire [MASK_W-1:0] held_union = same_grp ? union_ff : '0;
  wire [MASK_W-1:0] held_hi = same_grp ? hi_mask_ff : '0;
  wire lose_to_hi = priority_coupling && !d.high_priority;
  wire [MASK_W-1:0] won_mask = lose_to_hi ? (eff_mask & ~held_hi) : eff_mask;
  wire [MASK_W-1:0] applied = malformed ? '0 : won_mask;
  wire [MASK_W-1:0] nxt_union = held_union | applied;
  wire [MASK_W-1:0] nxt_hi = held_hi | ((priority_coupling && d.high_priority) ? applied : '0);
  wire [MASK_W-1:0] zero_fill = (nxt_union != '0) ? ~nxt_union : '0;

  // beam and stream label
  wire no_bf = (d.beam_selector == BEAM_NONE);
  wire unsched = unscheduled_marker_enable && d.has_ext10 &&
                 (d.beam_grouping_kind == BGK_UNSCHED) &&
                 (d.section_type == ST_BEAMW) &&
                 (d.ue_channel_label == UE_UNSCHED);

  sdfd_out_t nxt_out;
  always_comb begin
    nxt_out = '0;
    nxt_out.malformed = malformed;
    nxt_out.extension_present_flag = d.extension_present_flag;
    nxt_out.section_identifier = d.section_identifier;
    nxt_out.first_prb = first_prb;
    nxt_out.all_prbs = all_prbs;
    nxt_out.prb_total = prb_total;
    nxt_out.applied_mask = applied;
    nxt_out.zero_mask = malformed ? '0 : zero_fill;
    nxt_out.run_symbol = nxt_sym;
    nxt_out.symbol_set = malformed ? '0 : sym_set;
    nxt_out.no_beamforming = no_bf && !malformed;
    nxt_out.beam_selector = d.beam_selector;
    nxt_out.ue_channel_label = d.ue_channel_label;
    nxt_out.unscheduled = unsched && !malformed;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid_ff <= 1'b0;
      out_ff <= '0;
    end else if (buf_ready) begin
      out_valid_ff <= buf_valid;
      if (buf_valid) out_ff <= nxt_out;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sym_ff <= '0;
      prev_cnt_ff <= SYM_ONE;
      grp_prb_ff <= '0;
      grp_sym_ff <= '0;
      union_ff <= '0;
      hi_mask_ff <= '0;
    end else if (take) begin
      sym_ff <= nxt_sym;
      prev_cnt_ff <= d.symbol_count;
      grp_prb_ff <= first_prb;
      grp_sym_ff <= nxt_sym;
      union_ff <= nxt_union;
      hi_mask_ff <= nxt_hi;
    end
  end

  assign out_valid = out_valid_ff;
  assign out_desc = out_ff;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_bad_count_flagged: assert property (@(posedge ref_clk) disable iff (!rst_n)
    take && (d.symbol_count == SYM_RSV_HI) |=> out_valid && out_desc.malformed &&
      (out_desc.applied_mask == '0))
    else $error("reserved symbol count not flagged");
  a_zero_count_ext: assert property (@(posedge ref_clk) disable iff (!rst_n)
    take && (d.symbol_count == SYM_RSV_LO) && d.has_ext6 |=> !out_desc.malformed)
    else $error("zero count with ext 6 wrongly flagged");
  a_all_prb_start: assert property (@(posedge ref_clk) disable iff (!rst_n)
    take && (d.prb_count == PRB_ALL) |=> out_desc.all_prbs && (out_desc.first_prb == '0))
    else $error("all-prb start not forced to zero");
  a_default_mask: assert property (@(posedge ref_clk) disable iff (!rst_n)
    take && !d.mask_given && !malformed && !priority_coupling |=>
      (out_desc.applied_mask == MASK_ALL) && (out_desc.zero_mask == '0))
    else $error("default mask not all ones");
  a_no_beam_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
    take && !malformed |=> out_desc.no_beamforming == ($past(d.beam_selector) == '0))
    else $error("no-beamforming flag wrong");
  a_group_scale: assert property (@(posedge ref_clk) disable iff (!rst_n)
    take && (d.section_type != ST_CHINFO) |=> out_desc.prb_total == TOT_W'($past(d.prb_count)))
    else $error("group size applied outside type 6");
  a_unsched_mark: assert property (@(posedge ref_clk) disable iff (!rst_n)
    take && !unscheduled_marker_enable |=> !out_desc.unscheduled)
    else $error("unscheduled mark while disabled");
  a_symbol_advance: assert property (@(posedge ref_clk) disable iff (!rst_n)
    take && !d.first_of_msg && !d.symbol_advance_flag |=> out_desc.run_symbol == $past(sym_ff))
    else $error("running symbol moved without advance flag");
  a_bitmap_used: assert property (@(posedge ref_clk) disable iff (!rst_n)
    take && d.has_ext19 && !malformed |=> out_desc.symbol_set == $past(d.symbol_set_bitmap))
    else $error("bitmap not used with extension");
  a_out_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    out_valid && !out_ready |=> out_valid && $stable(out_desc))
    else $error("output changed while stalled");
  a_first_prb_pass: assert property (@(posedge ref_clk) disable iff (!rst_n)
    take && (d.prb_count != PRB_ALL) |=> out_desc.first_prb == $past(d.first_prb_index))
    else $error("first prb index not passed through");
  a_priority_win: assert property (@(posedge ref_clk) disable iff (!rst_n)
    take && lose_to_hi |=> (out_desc.applied_mask & $past(held_hi)) == '0)
    else $error("low priority kept a won subcarrier");
  a_unsched_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
    take && unscheduled_marker_enable && d.has_ext10 && !malformed &&
      (d.beam_grouping_kind == BGK_UNSCHED) && (d.section_type == ST_BEAMW) &&
      (d.ue_channel_label == UE_UNSCHED) |=> out_desc.unscheduled)
    else $error("unscheduled marker not decoded");
  a_malformed_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
    take && malformed |=> (out_desc.symbol_set == '0) && !out_desc.no_beamforming)
    else $error("malformed description still processed");
  c_malformed: cover property (@(posedge ref_clk) disable iff (!rst_n)
    out_valid && out_desc.malformed);
  c_priority_clip: cover property (@(posedge ref_clk) disable iff (!rst_n)
    take && lose_to_hi && ((eff_mask & held_hi) != '0));
  c_fifo_full: cover property (@(posedge ref_clk) disable iff (!rst_n)
    in_valid && !in_ready);
  c_unsched: cover property (@(posedge ref_clk) disable iff (!rst_n)
    out_valid && out_desc.unscheduled);
endmodule // sdfd_decoder

// ----------------------------------------------------------------
// input buffer module
// ----------------------------------------------------------------
module sdfd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // fill side
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [WIDTH-1:0] wr_data,
  // drain side
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [WIDTH-1:0] rd_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_ff;
  logic [AW-1:0] rp_ff;
  logic [AW:0] cnt_ff;
  logic full_ff;
  wire do_wr = wr_valid && !full_ff;
  wire do_rd = rd_ready && (cnt_ff != '0);
  wire [AW:0] nxt_cnt = cnt_ff + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};

  assign wr_ready = !full_ff;
  assign rd_valid = (cnt_ff != '0);
  assign rd_data = mem[rp_ff];

  always_ff @(posedge ref_clk) begin
    if (do_wr) mem[wp_ff] <= wr_data;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
      full_ff <= 1'b0;
    end else begin
      if (do_wr) wp_ff <= (wp_ff == AW'(DEPTH-1)) ? '0 : wp_ff + 1'b1;
      if (do_rd) rp_ff <= (rp_ff == AW'(DEPTH-1)) ? '0 : rp_ff + 1'b1;
      cnt_ff <= nxt_cnt;
      full_ff <= (nxt_cnt == (AW+1)'(DEPTH));
    end
  end

  a_full_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
    full_ff == (cnt_ff == (AW+1)'(DEPTH)))
    else $error("full flag out of step with count");
endmodule // sdfd_fifo
`default_nettype wire

// >>> hdl/sdfd_fifo.sv
// buffer: holds no logic; the buffer module sits in the decoder file

// >>> hdl/sdfd_pkg.sv
// package: field widths, codes and carriers of the section descriptor decoder
package sdfd_pkg;
  localparam int MASK_W = 12;
  localparam int PRB_W = 10;
  localparam int CNT_W = 8;
  localparam int SYM_W = 4;
  localparam int SYMS = 14;
  localparam int BEAM_W = 15;
  localparam int GRP_W = 8;
  localparam int TOT_W = 16;
  localparam int FIFO_DEPTH = 16;
  localparam logic [MASK_W-1:0] MASK_ALL = 12'hfff;
  localparam logic [CNT_W-1:0] PRB_ALL = 8'h00;
  localparam logic [PRB_W-1:0] PRB_ZERO = 10'h000;
  localparam logic [SYM_W-1:0] SYM_RSV_LO = 4'h0;
  localparam logic [SYM_W-1:0] SYM_RSV_HI = 4'hf;
  localparam logic [SYM_W-1:0] SYM_ONE = 4'h1;
  localparam logic [BEAM_W-1:0] BEAM_NONE = 15'h0000;
  localparam logic [BEAM_W-1:0] UE_UNSCHED = 15'h7fff;
  localparam logic [1:0] BGK_UNSCHED = 2'h2;
  localparam logic [3:0] ST_CHINFO = 4'h6;
  localparam logic [3:0] ST_BEAMW = 4'h5;

  // one received section description, fields already pulled from the message
  typedef struct packed {
    logic first_of_msg;
    logic [SYM_W-1:0] start_symbol;
    logic [3:0] section_type;
    logic [11:0] section_identifier;
    logic symbol_advance_flag;
    logic extension_present_flag;
    logic has_ext6;
    logic has_ext10;
    logic has_ext12;
    logic has_ext19;
    logic [1:0] beam_grouping_kind;
    logic [SYMS-1:0] symbol_set_bitmap;
    logic high_priority;
    logic mask_given;
    logic [MASK_W-1:0] subcarrier_mask;
    logic [PRB_W-1:0] first_prb_index;
    logic [CNT_W-1:0] prb_count;
    logic [SYM_W-1:0] symbol_count;
    logic [BEAM_W-1:0] beam_selector;
    logic [BEAM_W-1:0] ue_channel_label;
  } sdfd_desc_t;

  // decoded result of one description
  typedef struct packed {
    logic malformed;
    logic extension_present_flag;
    logic [11:0] section_identifier;
    logic [PRB_W-1:0] first_prb;
    logic all_prbs;
    logic [TOT_W-1:0] prb_total;
    logic [MASK_W-1:0] applied_mask;
    logic [MASK_W-1:0] zero_mask;
    logic [SYM_W-1:0] run_symbol;
    logic [SYMS-1:0] symbol_set;
    logic no_beamforming;
    logic [BEAM_W-1:0] beam_selector;
    logic [BEAM_W-1:0] ue_channel_label;
    logic unscheduled;
  } sdfd_out_t;
endpackage

// >>> verification/sdfd_du_model.sv
// model: distributed unit offering section descriptions in order
`timescale 1ns/1ps
`default_nettype none
module sdfd_du_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // pacing: one idle cycle after each taken word
  input wire logic gap,
  // descriptions towards the decoder
  output logic in_valid,
  input wire logic in_ready,
  output sdfd_pkg::sdfd_desc_t in_desc
);
  import sdfd_pkg::*;
  sdfd_desc_t q[$];
  logic taken = 1'b0;
  logic idle;
  initial begin
    in_valid = 1'b0;
    in_desc = '0;
  end
  task automatic send(input sdfd_desc_t d);
    q.push_back(d);
  endtask
  always @(posedge ref_clk) taken <= in_valid && in_ready;
  // a word is held until taken; an idle bus inverts every bit of its word each cycle
  always @(negedge ref_clk) begin
    idle = taken & gap;
    if (taken) begin
      void'(q.pop_front());
    end
    if (rst_n && !idle && q.size() > 0) begin
      in_valid <= 1'b1;
      in_desc <= q[0];
    end else begin
      in_valid <= 1'b0;
      in_desc <= ~in_desc;
    end
  end
endmodule // sdfd_du_model
`default_nettype wire

// >>> verification/test_section_descriptor_field_decoder.sv
// bench: section descriptor field decoder fed by a distributed unit model
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module test_section_descriptor_field_decoder;
  import sdfd_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic pc = 1'b0;
  logic ume = 1'b0;
  logic [GRP_W-1:0] cgs = 8'h04;
  logic in_valid, in_ready, out_valid, gap = 1'b0;
  logic out_ready = 1'b0;
  logic sink_on = 1'b1;
  logic stall = 1'b0;
  logic [11:0] sid = 12'h000;
  sdfd_desc_t in_desc, dd;
  sdfd_out_t out_desc, ex;
  sdfd_out_t exp_q[$];
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;
  int n;
  sdfd_decoder u_sdfd_decoder (.ref_clk(ref_clk), .rst_n(rst_n), .priority_coupling(pc),
    .unscheduled_marker_enable(ume), .channel_info_group_size(cgs), .in_valid(in_valid),
    .in_ready(in_ready), .in_desc(in_desc), .out_valid(out_valid), .out_ready(out_ready),
    .out_desc(out_desc));
  sdfd_du_model u_sdfd_du_model (.ref_clk(ref_clk), .rst_n(rst_n), .gap(gap),
    .in_valid(in_valid), .in_ready(in_ready), .in_desc(in_desc));
  always #2.5 ref_clk = ~ref_clk;
  always @(negedge ref_clk) out_ready <= stall ? ~out_ready : sink_on;
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      $display("wrong value at %0t: run did not finish", $time);
      results();
    end
  end
  // every taken output word is compared with the oldest expectation
  always @(posedge ref_clk) begin
    if (rst_n && out_valid === 1'b1 && out_ready === 1'b1) begin
      ex = exp_q.size() > 0 ? exp_q.pop_front() : '1;
      `CHK(out_desc, ex)
    end
  end
  function automatic sdfd_desc_t mkd(logic f, logic [3:0] st, logic adv, logic [3:0] e,
    logic [11:0] mk, logic [9:0] fp, logic [7:0] cnt, logic [3:0] ns, logic [14:0] bm);
    sdfd_desc_t d;
    d = '0;
    d.first_of_msg = f;
    d.start_symbol = st;
    d.section_type = 4'h1;
    d.section_identifier = sid;
    d.symbol_advance_flag = adv;
    {d.has_ext6, d.has_ext10, d.has_ext12, d.has_ext19} = e;
    d.extension_present_flag = |e;
    d.symbol_set_bitmap = 14'h00a5;
    d.mask_given = 1'b1;
    d.subcarrier_mask = mk;
    d.first_prb_index = fp;
    d.prb_count = cnt;
    d.symbol_count = ns;
    d.beam_selector = bm;
    d.ue_channel_label = 15'h0055;
    return d;
  endfunction
  task automatic tx(sdfd_desc_t d, logic m, logic [9:0] f, logic a, logic [15:0] t,
    logic [11:0] am, logic [11:0] zm, logic [3:0] rs, logic [13:0] ss, logic nb, logic un);
    exp_q.push_back(sdfd_out_t'{m, d.extension_present_flag, d.section_identifier, f, a, t,
      am, zm, rs, ss, nb, d.beam_selector, d.ue_channel_label, un});
    u_sdfd_du_model.send(d);
  endtask
  task automatic drain();
    n = 0;
    while (exp_q.size() > 0 && n < 400) begin
      @(negedge ref_clk);
      n++;
    end
    repeat (3) @(negedge ref_clk);
    `CHK(exp_q.size(), 0)
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    rst_n = 1'b1;
    gap = 1'b1;
    dd = mkd(1, 4'h2, 0, 4'h0, 12'h123, 10'h7, 8'h5, 4'h3, 15'h0);
    dd.mask_given = 1'b0;
    tx(dd, 0, 10'h7, 0, 16'h5, 12'hfff, 12'h0, 4'h2, 14'h1c, 1, 0);
    dd = mkd(0, 4'h2, 1, 4'h0, 12'hf00, 10'h7, 8'h1, 4'h1, 15'h1234);
    tx(dd, 0, 10'h7, 0, 16'h1, 12'hf00, 12'h0ff, 4'h5, 14'h20, 0, 0);
    dd = mkd(0, 4'h2, 0, 4'h0, 12'h0f0, 10'h7, 8'h1, 4'h1, 15'h1234);
    tx(dd, 0, 10'h7, 0, 16'h1, 12'h0f0, 12'h00f, 4'h5, 14'h20, 0, 0);
    drain();
    gap = 1'b0;
    dd = mkd(1, 4'hc, 0, 4'h0, 12'hfff, 10'h21, 8'h0, 4'h4, 15'h7fff);
    tx(dd, 0, 10'h0, 1, 16'h0, 12'hfff, 12'h0, 4'hc, 14'h3000, 0, 0);
    dd = mkd(0, 4'hc, 1, 4'h0, 12'hfff, 10'h1, 8'h1, 4'hf, 15'h0);
    tx(dd, 1, 10'h1, 0, 16'h1, 12'h0, 12'h0, 4'h0, 14'h0, 0, 0);
    dd = mkd(0, 4'hc, 1, 4'h0, 12'hfff, 10'h1, 8'h1, 4'h0, 15'h0);
    tx(dd, 1, 10'h1, 0, 16'h1, 12'h0, 12'h0, 4'hf, 14'h0, 0, 0);
    dd = mkd(0, 4'hc, 1, 4'h8, 12'hfff, 10'h2, 8'h1, 4'h0, 15'h0);
    tx(dd, 0, 10'h2, 0, 16'h1, 12'hfff, 12'h0, 4'hf, 14'ha5, 1, 0);
    dd = mkd(0, 4'hc, 0, 4'h1, 12'hfff, 10'h3, 8'h1, 4'h0, 15'h0);
    tx(dd, 1, 10'h3, 0, 16'h1, 12'h0, 12'h0, 4'hf, 14'h0, 0, 0);
    dd = mkd(0, 4'hc, 0, 4'h3, 12'hfff, 10'h4, 8'h1, 4'h2, 15'h0);
    tx(dd, 0, 10'h4, 0, 16'h1, 12'hfff, 12'h0, 4'hf, 14'ha5, 1, 0);
    dd = mkd(1, 4'h0, 0, 4'h0, 12'hfff, 10'h5, 8'h3, 4'h1, 15'h0);
    dd.section_type = ST_CHINFO;
    tx(dd, 0, 10'h5, 0, 16'hc, 12'hfff, 12'h0, 4'h0, 14'h1, 1, 0);
    dd = mkd(1, 4'h0, 0, 4'h0, 12'hfff, 10'h6, 8'h3, 4'h1, 15'h0);
    tx(dd, 0, 10'h6, 0, 16'h3, 12'hfff, 12'h0, 4'h0, 14'h1, 1, 0);
    drain();
    ume = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (i == 3) drain();
      if (i == 3) ume = 1'b0;
      dd = mkd(1, 4'h0, 0, 4'h4, 12'hfff, 10'h8, 8'h1, 4'h1, 15'h2);
      dd.section_type = ST_BEAMW;
      dd.beam_grouping_kind = i == 2 ? 2'h1 : BGK_UNSCHED;
      dd.ue_channel_label = i == 1 ? 15'h7ffe : UE_UNSCHED;
      tx(dd, 0, 10'h8, 0, 16'h1, 12'hfff, 12'h0, 4'h0, 14'h1, 0, i == 0);
    end
    drain();
    pc = 1'b1;
    dd = mkd(1, 4'h0, 0, 4'h0, 12'hff0, 10'h9, 8'h1, 4'h1, 15'h0);
    dd.high_priority = 1'b1;
    tx(dd, 0, 10'h9, 0, 16'h1, 12'hff0, 12'h00f, 4'h0, 14'h1, 1, 0);
    dd = mkd(0, 4'h0, 0, 4'h0, 12'h0ff, 10'h9, 8'h1, 4'h1, 15'h0);
    tx(dd, 0, 10'h9, 0, 16'h1, 12'h00f, 12'h0, 4'h0, 14'h1, 1, 0);
    drain();
    pc = 1'b0;
    sink_on = 1'b0;
    for (int i = 0; i < 20; i++) begin
      sid = 12'(i);
      dd = mkd(1, 4'h0, 0, 4'h0, 12'hfff, 10'(i), 8'h1, 4'h1, 15'h1);
      tx(dd, 0, 10'(i), 0, 16'h1, 12'hfff, 12'h0, 4'h0, 14'h1, 0, 0);
    end
    n = 0;
    while (in_ready !== 1'b0 && n < 60) begin
      @(negedge ref_clk);
      n++;
    end
    `CHK(in_ready, 1'b0)
    stall = 1'b1;
    drain();
    results();
  end
endmodule // test_section_descriptor_field_decoder
`default_nettype wire
